/* File: src/llpc_checker.sv */
// Lane pattern checker top: byte register file on clk, frame checkers on lclk.
// Assumes lane_sample and bank_active come from lclk logic, one sample per edge.
// What this block does
// [R1] A bank enable bit starts checking on that bank only when the bank is active.
// [R2] Any bank enable set blocks received samples from the converter output path.
// [R3] Realign-hold stops strobe edges from resetting the frame counters.
// [R4] Strobe alignment alarms keep firing while realignment is held.
// [R5] Single-run mode halts on first failing frame; continuous mode runs until stopped.
// [R6] Trigger rising write starts checking at the next frame start.
// [R7] Trigger rising write clears all four bank failure status registers.
// [R8] Writing trigger to zero stops any running check.
// [R9] Read-only running flag per bank while checking is active.
// [R10] Trigger may stay one after a halt; running flags tell the difference.
// [R11] Bank failure summary bit is high exactly while its status is nonzero.
// [R12] Writable shared pattern memory of eight sixteen-bit words.
// [R13] Pattern bit 12 is strobe level, bits 11..0 data lanes, 15..13 reserved.
// [R14] Software puts the frame's first sample at the lowest pattern word.
// [R15] Software programs strobe zero in falling-edge pattern words.
// [R16] Bank failures are kept in 13-bit write-one-to-clear status fields.
// [R17] Status bit 12 flags strobe mismatch, bits 11..0 data lane mismatches.
// [R18] Single-run failure keeps the whole failing frame in the bank capture memory.
// [R19] Each sample is compared lane by lane and differing lanes set status bits.
// [R20] Continuous mode keeps failure bits until software or a new start clears them.
`timescale 1ns/1ns
`include "llpc_defines.svh"

module llpc_checker (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lclk,
  input wire logic [`LLPC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  input wire llpc_pkg::llpc_banks_t lane_sample,
  input wire logic [`LLPC_NBANKS-1:0] bank_active,
  output llpc_pkg::llpc_banks_t dac_data,
  output logic path_block,
  output logic [`LLPC_NBANKS-1:0] strobe_alarm
);
  import llpc_pkg::*;

  // =============================================================
  // Address helpers
  function automatic logic in_rng(
    input logic [`LLPC_ADDR_W-1:0] a,
    input logic [`LLPC_ADDR_W-1:0] base,
    input logic [`LLPC_ADDR_W-1:0] len
  );
    return (a >= base) && (a < (base + len));
  endfunction

  function automatic logic [7:0] pick_byte(input logic [15:0] w, input logic hi);
    return hi ? w[15:8] : w[7:0];
  endfunction

  // =============================================================
  // State and wires
  llpc_host_st_t h_q, h_d;
  llpc_link_st_t l_q, l_d;
  llpc_lvl_t host_lvl;
  llpc_lvl_t lv;
  logic start_w;
  logic [`LLPC_NBANKS-1:0] run_l;
  logic [`LLPC_NBANKS-1:0] alarm_l;
  llpc_banks_t miss_l;
  llpc_frame_t [`LLPC_NBANKS-1:0] cap_l;

  llpc_bank_if bank_if [`LLPC_NBANKS] ();

  assign host_lvl.pat_tgl = h_q.pat_tgl;
  assign host_lvl.trig = h_q.ctrl[`LLPC_CTRL_TRIG_BIT];
  assign host_lvl.hold = h_q.cfg[`LLPC_CFG_HOLD_BIT];
  assign host_lvl.cont = h_q.cfg[`LLPC_CFG_CONT_BIT];
  assign host_lvl.en = h_q.cfg[`LLPC_CFG_EN_LSB +: `LLPC_NBANKS];
  assign lv = l_q.lvl_sync[1];
  // Level sync turns a 0-to-1 trigger into one start pulse per run
  assign start_w = lv.trig & ~l_q.trig_prev; // [R6]

  // =============================================================
  // Per-bank checkers
  for (genvar g = 0; g < `LLPC_NBANKS; g++) begin : g_bank
    assign bank_if[g].sample = lane_sample[g];
    assign bank_if[g].pattern = l_q.pat;
    assign bank_if[g].start = start_w;
    assign bank_if[g].stop = ~lv.trig; // [R8]
    assign bank_if[g].en = lv.en[g] & bank_active[g]; // [R1]
    assign bank_if[g].hold = lv.hold; // [R3]
    assign bank_if[g].cont = lv.cont; // [R5]
    assign run_l[g] = bank_if[g].run;
    assign alarm_l[g] = bank_if[g].alarm;
    assign miss_l[g] = bank_if[g].miss;
    assign cap_l[g] = bank_if[g].cap;

    llpc_bank u_bank (
      .lclk(lclk),
      .arst_n(arst_n),
      .bus(bank_if[g])
    );
  end

  // =============================================================
  // Register domain
  always_comb begin
    llpc_banks_t clr;
    llpc_banks_t inc;
    logic [`LLPC_ADDR_W-1:0] off_pat;
    logic [`LLPC_ADDR_W-1:0] off_stat;
    logic [`LLPC_ADDR_W-1:0] off_cap;
    logic [7:0] rd;
    logic got;
    clr = '0;
    inc = '0;
    off_pat = reg_addr - `LLPC_OFS_PAT;
    off_stat = reg_addr - `LLPC_OFS_STAT;
    off_cap = reg_addr - `LLPC_OFS_CAP;
    rd = '0;
    got = 1'b0;
    h_d = h_q;

    h_d.run_sync[0] = run_l;
    h_d.run_sync[1] = h_q.run_sync[0];

    // Failure words arrive by toggle handshake; the held word is stable
    // from the toggle until the matching acknowledge returns
    h_d.req_sync[0] = l_q.req;
    h_d.req_sync[1] = h_q.req_sync[0];
    h_d.req_sync[2] = h_q.req_sync[1];
    got = h_q.req_sync[1] ^ h_q.req_sync[2];
    if (got) begin
      inc = l_q.held;
      h_d.ack = h_q.req_sync[1];
    end

    if (reg_wr) begin
      if (reg_addr == `LLPC_OFS_CFG) begin
        h_d.cfg = reg_wdata;
      end else if (reg_addr == `LLPC_OFS_CTRL) begin
        if (reg_wdata[`LLPC_CTRL_TRIG_BIT] && !h_q.ctrl[`LLPC_CTRL_TRIG_BIT]) begin
          clr = '1; // [R7]
        end
        // Trigger stays as written even after a halt
        h_d.ctrl = reg_wdata; // [R10]
      end else if (in_rng(reg_addr, `LLPC_OFS_PAT, `LLPC_PAT_BYTES)) begin
        if (off_pat[0]) begin
          h_d.pat[off_pat[3:1]][15:8] = reg_wdata; // [R12]
        end else begin
          h_d.pat[off_pat[3:1]][7:0] = reg_wdata; // [R12]
        end
        h_d.pat_tgl = ~h_q.pat_tgl;
      end else if (in_rng(reg_addr, `LLPC_OFS_STAT, `LLPC_STAT_BYTES)) begin
        if (off_stat[0]) begin
          clr[off_stat[2:1]][`LLPC_LANE_W-1:8] = reg_wdata[`LLPC_LANE_W-9:0]; // [R16]
        end else begin
          clr[off_stat[2:1]][7:0] = reg_wdata; // [R16]
        end
      end
    end

    // A failure landing in the clearing cycle survives the clear
    h_d.stat = (h_q.stat & ~clr) | inc; // [R16] [R17] [R20]

    if (reg_addr == `LLPC_OFS_CFG) begin
      rd = h_q.cfg;
    end else if (reg_addr == `LLPC_OFS_CTRL) begin
      rd = h_q.ctrl;
    end else if (reg_addr == `LLPC_OFS_SUM) begin
      for (int b = 0; b < `LLPC_NBANKS; b++) begin
        rd[b] = |h_q.stat[b]; // [R11]
        rd[`LLPC_SUM_RUN_LSB + b] = h_q.run_sync[1][b]; // [R9]
      end
    end else if (in_rng(reg_addr, `LLPC_OFS_PAT, `LLPC_PAT_BYTES)) begin
      rd = pick_byte(h_q.pat[off_pat[3:1]], off_pat[0]);
    end else if (in_rng(reg_addr, `LLPC_OFS_STAT, `LLPC_STAT_BYTES)) begin
      rd = pick_byte(16'(h_q.stat[off_stat[2:1]]), off_stat[0]);
    end else if (in_rng(reg_addr, `LLPC_OFS_CAP, `LLPC_CAP_BYTES)) begin
      // Capture words change only as a bank halts, so they are read
      // across domains only once the synced running flag is low
      if (!h_q.run_sync[1][off_cap[5:4]]) begin
        rd = pick_byte(16'(cap_l[off_cap[5:4]][off_cap[3:1]]), off_cap[0]); // [R18]
      end
    end
    if (reg_rd) begin
      h_d.rdata = rd;
    end
  end

  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      h_q <= '0;
      h_q.cfg <= `LLPC_CFG_RESET;
      h_q.ctrl <= `LLPC_CTRL_RESET;
      h_q.pat <= {`LLPC_FRAME_LEN{`LLPC_PAT_RESET}};
    end else begin
      h_q <= h_d;
    end
  end

  // =============================================================
  // Link domain
  always_comb begin
    llpc_banks_t merged;
    logic busy;
    merged = '0;
    busy = 1'b0;
    l_d = l_q;

    l_d.lvl_sync[0] = host_lvl;
    l_d.lvl_sync[1] = l_q.lvl_sync[0];
    l_d.trig_prev = lv.trig;
    l_d.ack_sync[0] = h_q.ack;
    l_d.ack_sync[1] = l_q.ack_sync[0];

    // Pattern copy is taken after its change toggle has crossed, so the
    // register-side words have already settled
    l_d.pat_prev = lv.pat_tgl;
    if (lv.pat_tgl != l_q.pat_prev) begin
      for (int w = 0; w < `LLPC_FRAME_LEN; w++) begin
        l_d.pat[w] = h_q.pat[w][`LLPC_LANE_W-1:0]; // [R13]
      end
    end

    // Failures gather here while a word is in flight; a new start drops
    // stale ones so a run begins clean
    merged = (start_w ? '0 : l_q.pend) | miss_l; // [R7] [R20]
    busy = l_q.req ^ l_q.ack_sync[1];
    if (!busy && (merged != '0)) begin
      l_d.held = merged;
      l_d.pend = '0;
      l_d.req = ~l_q.req;
    end else begin
      l_d.pend = merged;
    end

    l_d.block = |lv.en; // [R2]
    for (int b = 0; b < `LLPC_NBANKS; b++) begin
      l_d.dac[b] = (|lv.en) ? '0 : lane_sample[b]; // [R2]
    end
  end

  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      l_q <= '0;
    end else begin
      l_q <= l_d;
    end
  end

  // =============================================================
  // Outputs
  assign reg_rdata = h_q.rdata;
  assign dac_data = l_q.dac;
  assign path_block = l_q.block;
  assign strobe_alarm = alarm_l;
endmodule

/* File: inc/llpc_defines.svh */
// Constants of the lane pattern checker: offsets, field positions, reset values.
// Included by the package and by every design file that needs a number.
`ifndef LLPC_DEFINES_SVH
`define LLPC_DEFINES_SVH

// =============================================================
// Sizes
`define LLPC_NBANKS 4
`define LLPC_FRAME_LEN 8
`define LLPC_LANE_W 13
`define LLPC_STROBE_BIT 12
`define LLPC_ADDR_W 12

// =============================================================
// Register byte offsets
`define LLPC_OFS_CFG 12'h710
`define LLPC_OFS_CTRL 12'h711
`define LLPC_OFS_SUM 12'h712
`define LLPC_OFS_PAT 12'h720
`define LLPC_OFS_STAT 12'h750
`define LLPC_OFS_CAP 12'h760
`define LLPC_PAT_BYTES 12'h010
`define LLPC_STAT_BYTES 12'h008
`define LLPC_CAP_BYTES 12'h040

// =============================================================
// Field positions
`define LLPC_CFG_EN_LSB 4
`define LLPC_CFG_HOLD_BIT 1
`define LLPC_CFG_CONT_BIT 0
`define LLPC_CTRL_TRIG_BIT 0
`define LLPC_SUM_RUN_LSB 4

// =============================================================
// Reset values
`define LLPC_CFG_RESET 8'h00
`define LLPC_CTRL_RESET 8'h00
`define LLPC_PAT_RESET 16'h0000

`endif

/* File: inc/llpc_pkg.sv */
// Types shared by the lane pattern checker and its per-bank checker.
// Assumes llpc_defines.svh is on the include path.
`include "llpc_defines.svh"

package llpc_pkg;

  // =============================================================
  // Data shapes
  typedef logic [`LLPC_LANE_W-1:0] llpc_lane_t;
  typedef llpc_lane_t [`LLPC_FRAME_LEN-1:0] llpc_frame_t;
  typedef llpc_lane_t [`LLPC_NBANKS-1:0] llpc_banks_t;
  typedef logic [$clog2(`LLPC_FRAME_LEN)-1:0] llpc_idx_t;

  // =============================================================
  // Per-bank checker states, Gray along idle, armed, run, halt
  typedef enum logic [1:0] {
    LLPC_IDLE = 2'b00,
    LLPC_ARMED = 2'b01,
    LLPC_RUN = 2'b11,
    LLPC_HALT = 2'b10
  } llpc_chk_st_t;

  // Levels that cross from the register domain to the link domain
  typedef struct packed {
    logic pat_tgl;
    logic trig;
    logic hold;
    logic cont;
    logic [`LLPC_NBANKS-1:0] en;
  } llpc_lvl_t;

  // =============================================================
  // State records
  typedef struct packed {
    llpc_chk_st_t st;
    llpc_idx_t fcnt;
    logic strb_prev;
    logic err;
    logic alarm;
    llpc_lane_t miss;
    llpc_frame_t shadow;
    llpc_frame_t cap;
  } llpc_bank_st_t;

  typedef struct packed {
    logic [7:0] cfg;
    logic [7:0] ctrl;
    logic [`LLPC_FRAME_LEN-1:0][15:0] pat;
    llpc_banks_t stat;
    logic pat_tgl;
    logic [1:0][`LLPC_NBANKS-1:0] run_sync;
    logic [2:0] req_sync;
    logic ack;
    logic [7:0] rdata;
  } llpc_host_st_t;

  typedef struct packed {
    llpc_lvl_t [1:0] lvl_sync;
    logic trig_prev;
    logic pat_prev;
    llpc_frame_t pat;
    llpc_banks_t pend;
    llpc_banks_t held;
    logic req;
    logic [1:0] ack_sync;
    llpc_banks_t dac;
    logic block;
  } llpc_link_st_t;

endpackage

/* File: inc/llpc_bank_if.sv */
// Carrier between the checker top and one per-bank checker.
// Everything on it belongs to the link clock domain.
`timescale 1ns/1ns

interface llpc_bank_if;
  import llpc_pkg::*;

  llpc_lane_t sample;
  llpc_frame_t pattern;
  logic start;
  logic stop;
  logic en;
  logic hold;
  logic cont;
  logic run;
  logic alarm;
  llpc_lane_t miss;
  llpc_frame_t cap;

  modport ctl (
    output sample, pattern, start, stop, en, hold, cont,
    input run, alarm, miss, cap
  );
  modport chk (
    input sample, pattern, start, stop, en, hold, cont,
    output run, alarm, miss, cap
  );
endinterface

/* File: src/llpc_bank.sv */
// Per-bank frame checker on the link clock.
// Assumes its controls are already synchronised to lclk by the top.
`timescale 1ns/1ns
`include "llpc_defines.svh"

module llpc_bank (
  input wire logic lclk,
  input wire logic arst_n,
  llpc_bank_if.chk bus
);
  import llpc_pkg::*;

  llpc_bank_st_t s_q, s_d;

  // =============================================================
  // Next state
  always_comb begin
    llpc_lane_t mism;
    llpc_idx_t cur;
    logic edge_s;
    logic checking;
    logic err_now;
    mism = '0;
    cur = '0;
    edge_s = 1'b0;
    checking = 1'b0;
    err_now = 1'b0;
    s_d = s_q;
    edge_s = bus.sample[`LLPC_STROBE_BIT] & ~s_q.strb_prev;
    // Hold keeps the counter free running so the strobe lane may carry any pattern
    cur = (edge_s && !bus.hold) ? '0 : s_q.fcnt; // [R3]
    s_d.fcnt = cur + 1'b1;
    s_d.strb_prev = bus.sample[`LLPC_STROBE_BIT];
    // Misplaced strobe edge is flagged whether or not realignment is held
    s_d.alarm = edge_s && (s_q.fcnt != '0); // [R4]
    mism = bus.sample ^ bus.pattern[cur]; // [R19] [R14]
    s_d.miss = '0;
    checking = (s_q.st == LLPC_RUN) || ((s_q.st == LLPC_ARMED) && (cur == '0)); // [R6]
    case (s_q.st)
      LLPC_IDLE: begin
        if (bus.start && bus.en) begin
          s_d.st = LLPC_ARMED;
        end
      end
      LLPC_ARMED: begin
        if (cur == '0) begin
          s_d.st = LLPC_RUN;
        end
      end
      default: begin
      end
    endcase
    if (checking) begin
      s_d.miss = mism; // [R19]
      s_d.shadow[cur] = bus.sample;
      err_now = ((cur == '0) ? 1'b0 : s_q.err) | (|mism);
      s_d.err = err_now;
      // Halt only at frame end so the whole failing frame is kept
      if ((cur == llpc_idx_t'(`LLPC_FRAME_LEN - 1)) && err_now && !bus.cont) begin
        s_d.st = LLPC_HALT; // [R5]
        s_d.cap = s_d.shadow; // [R18]
      end
    end
    if (bus.stop || !bus.en) begin
      s_d.st = LLPC_IDLE; // [R8] [R1]
    end
  end

  // =============================================================
  // State register
  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign bus.run = (s_q.st == LLPC_RUN); // [R9]
  assign bus.alarm = s_q.alarm;
  assign bus.miss = s_q.miss;
  assign bus.cap = s_q.cap;
endmodule

/* File: verification/llpc_chk.sv */
// Concurrent checks on the lane pattern checker top, seen from its ports only.
// Assumes the design's defines header and package are compiled first.
`timescale 1ns/1ns
`include "llpc_defines.svh"

module llpc_chk (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic lclk,
  input wire logic [`LLPC_ADDR_W-1:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire llpc_pkg::llpc_banks_t lane_sample,
  input wire llpc_pkg::llpc_banks_t dac_data,
  input wire logic path_block
);
  import llpc_pkg::*;
  // =============================================================
  // Shadow of the writable bytes, and what the last read must return
  logic [7:0] cfg_m, ctrl_m, exp_q;
  logic [1:0] kind_q;
  logic [15:0][7:0] pat_m;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      cfg_m <= 8'h00;
      ctrl_m <= 8'h00;
      pat_m <= '0;
      exp_q <= 8'h00;
      kind_q <= 2'd0;
    end else begin
      if (reg_wr && reg_addr == 12'h710) cfg_m <= reg_wdata;
      if (reg_wr && reg_addr == 12'h711) ctrl_m <= reg_wdata;
      if (reg_wr && reg_addr[11:4] == 8'h72) pat_m[reg_addr[3:0]] <= reg_wdata;
      kind_q <= 2'd0;
      exp_q <= 8'h00;
      if (reg_rd && reg_addr == 12'h710) begin
        kind_q <= 2'd1;
        exp_q <= cfg_m;
      end else if (reg_rd && reg_addr == 12'h711) begin
        kind_q <= 2'd1;
        exp_q <= ctrl_m;
      end else if (reg_rd && reg_addr[11:4] == 8'h72) begin
        kind_q <= 2'd2;
        exp_q <= pat_m[reg_addr[3:0]];
      end else if (reg_rd && reg_addr < 12'h710) begin
        kind_q <= 2'd3;
      end
    end
  end
  // =============================================================
  // Assertions
  chk_rd_hold: assert property (@(posedge clk) disable iff (!arst_n)
    !$past(reg_rd) |-> $stable(reg_rdata)) else $error("read data moved without a read");
  chk_cfg_rdbk: assert property (@(posedge clk) disable iff (!arst_n)
    kind_q == 2'd1 |-> reg_rdata == exp_q) else $error("control byte readback wrong");
  chk_pat_rdbk: assert property (@(posedge clk) disable iff (!arst_n)
    kind_q == 2'd2 |-> reg_rdata == exp_q) else $error("pattern byte readback wrong");
  chk_unmapped_zero: assert property (@(posedge clk) disable iff (!arst_n)
    kind_q == 2'd3 |-> reg_rdata == 8'h00) else $error("unmapped read not zero");
  chk_stat_rsv: assert property (@(posedge clk) disable iff (!arst_n)
    reg_rd && reg_addr[11:3] == 9'h0EA && reg_addr[0] |=> reg_rdata[7:5] == 3'b000)
    else $error("status reserved bits not zero");
  chk_trig_clear: assert property (@(posedge clk) disable iff (!arst_n)
    reg_wr && reg_addr == 12'h711 && reg_wdata[0] && !ctrl_m[0]
    ##[1:3] reg_rd && reg_addr == 12'h712 |=> reg_rdata[3:0] == 4'h0)
    else $error("failures left after trigger start");
  chk_block_zero: assert property (@(posedge lclk) disable iff (!arst_n)
    path_block |-> dac_data == '0) else $error("samples leak while blocked");
  chk_pass_thru: assert property (@(posedge lclk) disable iff (!arst_n)
    !path_block |-> dac_data == $past(lane_sample)) else $error("pass-through data wrong");
endmodule

bind llpc_checker llpc_chk u_chk (
  .clk(clk), .arst_n(arst_n), .lclk(lclk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_sample(lane_sample),
  .dac_data(dac_data), .path_block(path_block)
);

/* File: verification/llpc_fpga_model.sv */
// Far-end transmitter: repeating eight-sample frames on every bank.
// Assumes lclk runs continuously; a lane-mask error can be injected in one sample per frame.
`timescale 1ns/1ns
`include "llpc_defines.svh"

module llpc_fpga_model (
  input wire logic lclk,
  input wire logic arst_n,
  input wire logic [1:0] inj_bank,
  input wire logic [2:0] inj_idx,
  input wire logic [12:0] inj_mask,
  output llpc_pkg::llpc_banks_t lane_sample
);
  import llpc_pkg::*;
  logic [2:0] idx_q;
  // =============================================================
  // Strobe high only on sample 0, a rising-edge slot, so frames realign there
  always_ff @(posedge lclk or negedge arst_n) begin
    if (!arst_n) begin
      idx_q <= 3'd0;
      lane_sample <= '0;
    end else begin
      idx_q <= idx_q + 3'd1;
      for (int b = 0; b < 4; b++) begin
        lane_sample[b] <= {idx_q == 3'd0, 12'h5A0 | {9'h000, idx_q}}
          ^ ((b == inj_bank && idx_q == inj_idx) ? inj_mask : 13'h0000);
      end
    end
  end
endmodule

/* File: verification/tb_top.sv */
// Register-level tests of the lane pattern checker against a frame source.
// Assumes the checker is bound in from its own file.
`timescale 1ns/1ns
`include "llpc_defines.svh"

module tb_top;
  import llpc_pkg::*;
  logic clk, lclk, arst_n, reg_wr, reg_rd, path_block;
  logic [11:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata;
  logic [3:0] bank_active, strobe_alarm;
  llpc_banks_t lane_sample, dac_data;
  logic [1:0] inj_bank;
  logic [2:0] inj_idx;
  logic [12:0] inj_mask;
  logic [15:0] w;
  int err_total, n_compared;
  logic alarm_seen;
  logic alarm_clr;

  llpc_checker dut (.clk(clk), .arst_n(arst_n), .lclk(lclk), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .lane_sample(lane_sample), .bank_active(bank_active), .dac_data(dac_data),
    .path_block(path_block), .strobe_alarm(strobe_alarm));
  llpc_fpga_model u_fpga (.lclk(lclk), .arst_n(arst_n), .inj_bank(inj_bank),
    .inj_idx(inj_idx), .inj_mask(inj_mask), .lane_sample(lane_sample));

  // =============================================================
  // Clocks; the link clock is offset so the domains never line up
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    lclk = 1'b0;
    #7;
    forever begin
      #62 lclk = ~lclk;
      #63 lclk = ~lclk;
    end
  end
  // Startup misalignment raises an alarm too, so the flag is armed only for the hold test
  always @(posedge lclk) begin
    alarm_seen <= alarm_clr ? 1'b0 : (alarm_seen | (strobe_alarm[0] === 1'b1));
  end

  // =============================================================
  // Access tasks
  task cmp8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task wr(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    cmp8(reg_rdata, e);
  endtask
  task lw(input int n);
    repeat (n) @(posedge lclk);
  endtask
  // Held for exactly one frame so the error lands once
  task inject(input logic [1:0] b, input logic [2:0] i, input logic [12:0] m);
    @(posedge lclk);
    inj_bank <= b;
    inj_idx <= i;
    inj_mask <= m;
    lw(8);
    inj_mask <= 13'h0000;
  endtask
  task results();
    if (err_total == 0 && n_compared > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask

  initial begin
    #400000;
    err_total++;
    results();
  end

  // =============================================================
  // Tests
  initial begin
    {arst_n, reg_wr, reg_rd} = '0;
    alarm_clr = 1'b1;
    {reg_addr, reg_wdata, inj_bank, inj_idx, inj_mask} = '0;
    bank_active = 4'hF;
    repeat (6) @(posedge clk);
    arst_n <= 1'b1;
    lw(3);
    rd(12'h710, 8'h00);
    rd(12'h711, 8'h00);
    rd(12'h712, 8'h00);
    rd(12'h721, 8'h00);
    wr(12'h700, 8'h5A);
    rd(12'h700, 8'h00);
    wr(12'h710, 8'h0C);
    rd(12'h710, 8'h0C);
    wr(12'h711, 8'hFE);
    rd(12'h711, 8'hFE);
    wr(12'h711, 8'h00);
    for (int n = 0; n < 8; n++) begin
      w = {3'b000, n == 0, 12'h5A0 | n[11:0]};
      wr(12'h720 + 12'(2 * n), w[7:0]);
      wr(12'h721 + 12'(2 * n), w[15:8]);
    end
    rd(12'h720, 8'hA0);
    rd(12'h721, 8'h15);
    wr(12'h710, 8'hF0);
    lw(4);
    @(negedge lclk);
    cmp8({7'h00, path_block}, 8'h01);
    wr(12'h711, 8'h01);
    lw(24);
    rd(12'h712, 8'hF0);
    inject(2'd1, 3'd3, 13'h0005);
    lw(20);
    rd(12'h712, 8'hD2);
    rd(12'h711, 8'h01);
    rd(12'h752, 8'h05);
    rd(12'h753, 8'h00);
    rd(12'h776, 8'hA6);
    rd(12'h777, 8'h05);
    wr(12'h752, 8'h01);
    rd(12'h752, 8'h04);
    rd(12'h712, 8'hD2);
    wr(12'h711, 8'h00);
    lw(4);
    rd(12'h712, 8'h02);
    wr(12'h711, 8'h01);
    rd(12'h712, 8'h00);
    lw(24);
    rd(12'h712, 8'hF0);
    wr(12'h711, 8'h00);
    wr(12'h710, 8'hF1);
    @(posedge lclk);
    bank_active <= 4'h7;
    lw(4);
    wr(12'h711, 8'h01);
    lw(24);
    rd(12'h712, 8'h70);
    inject(2'd2, 3'd2, 13'h0800);
    lw(24);
    rd(12'h712, 8'h74);
    rd(12'h755, 8'h08);
    wr(12'h755, 8'h08);
    rd(12'h712, 8'h70);
    wr(12'h710, 8'hF3);
    lw(4);
    alarm_clr <= 1'b0;
    inject(2'd0, 3'd4, 13'h1000);
    lw(20);
    rd(12'h751, 8'h10);
    rd(12'h712, 8'h71);
    cmp8({7'h00, alarm_seen}, 8'h01);
    wr(12'h711, 8'h00);
    wr(12'h710, 8'h00);
    lw(6);
    rd(12'h712, 8'h01);
    cmp8({7'h00, path_block}, 8'h00);
    results();
  end
endmodule
